// File: logic/trf_framer.sv
/*
  transmit framer: bit sync, flags, word count, data field, padding,
  plus net busy indication. assumes the data field arrives already
  coded, one bit per data_req_out pulse, and pins reach it unsynchronised.
*/
`timescale 1ns/1ps
// Contract
// R1: word count covers count field and data
// R2: round up, pad zeros to 16-bit words
// R3: padding zeros bypass coding and interleave
// R4: send flags until radio flags arrive
// R5: at least one lead flag before data
// R6: radio sends a flag before its data
// R7: data field passes coded stream unchanged
// R8: bit sync is 64 alternating bits, one first
// R9: busy set when net busy sensed
// R10: busy cleared only when nothing sensed
// R11: optional net activity status report
// R12: packet mode sends no phasing bits
// R13: flag is zero, six ones, zero
module trf_framer #(
  parameter int unsigned BIT_CYCLES = trf_pkg::BIT_CYCLES_DFLT
) (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  // send request
  input  wire logic              phy_send_request_in,
  input  trf_pkg::trf_req_s      req_in,
  output logic                   req_ready_out,
  output logic                   done_out,
  // data field stream
  output logic                   data_req_out,
  input  wire logic              data_bit_in,
  // radio leads
  output logic                   tx_lead_out,
  input  wire logic              rx_lead_in,
  // net sensing
  input  wire logic              data_detect_in,
  input  wire logic              voice_detect_in,
  input  wire logic              report_en_in,
  output trf_pkg::trf_net_s      phy_status_report_out
);

  localparam logic [15:0] DIV_LAST = 16'(BIT_CYCLES - 1);

  trf_pkg::trf_main_s q;
  trf_pkg::trf_main_s d;
  logic               bit_en;
  logic               hit;
  logic               take;
  logic [16:0]        wcnt_sum;

  assign bit_en = (q.div == DIV_LAST);
  assign take   = phy_send_request_in && (q.st == trf_pkg::TRF_IDLE);
  // R1: count covers itself
  assign wcnt_sum = 17'(req_in.len) +
                    17'(trf_pkg::WCNT_BITS + trf_pkg::WORD_BITS - 1);

  // R4: watches the receive lead
  trf_flag_det u_flag_det (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .bit_en_in (bit_en),
    .bit_in    (q.sync[0]),
    .hit_out   (hit)
  );

  always_comb begin
    d         = q;
    d.done    = 1'b0;
    d.net.report = 1'b0;
    // pins: meta then sync, only sync reads meta
    d.meta = {voice_detect_in, data_detect_in, rx_lead_in};
    d.sync = q.meta;
    d.div  = bit_en ? trf_pkg::DIV_ZERO : q.div + 16'h0001;

    // R9: set on any activity
    if (q.sync[trf_pkg::NET_DET_W:1] != '0) begin
      d.net.busy = 1'b1;
    // R10: clear only with both quiet
    end else begin
      d.net.busy = 1'b0;
    end
    // R11: pulse on change when enabled
    d.net.report = report_en_in && (d.net.busy != q.net.busy);

    // R6: radio flag latched; set wins over clear
    if (hit) begin
      d.flag_seen = 1'b1;
    end else if (q.st == trf_pkg::TRF_IDLE) begin
      d.flag_seen = 1'b0;
    end

    case (q.st)
      trf_pkg::TRF_IDLE: begin
        if (bit_en) begin
          d.tx = trf_pkg::IDLE_LEVEL;
        end
        if (take) begin
          d.left   = req_in.len;
          d.wcnt   = 16'(wcnt_sum >> trf_pkg::WORD_SHIFT);
          // R2: zeros to next word boundary
          d.pad    = 4'(trf_pkg::PAD_ZERO - req_in.len[3:0]);
          d.packet = req_in.packet;
          d.cnt    = trf_pkg::CNT_ZERO;
          // R12: packet mode goes straight to flags
          if (req_in.packet) begin
            d.st = trf_pkg::TRF_FLAG;
          end else if (req_in.bitsync) begin
            d.st = trf_pkg::TRF_BSYNC;
          end else begin
            d.st = trf_pkg::TRF_WCNT;
          end
        end
      end
      trf_pkg::TRF_BSYNC: begin
        if (bit_en) begin
          // R8: one on even counts
          d.tx  = ~q.cnt[0];
          d.cnt = q.cnt + 7'h01;
          if (q.cnt == trf_pkg::CNT_BS_END) begin
            d.cnt = trf_pkg::CNT_ZERO;
            d.st  = trf_pkg::TRF_WCNT;
          end
        end
      end
      trf_pkg::TRF_FLAG: begin
        if (bit_en) begin
          // R13: delimiter pattern
          d.tx  = trf_pkg::FLAG_PATTERN[q.cnt[2:0]];
          d.cnt = q.cnt + 7'h01;
          if (q.cnt == trf_pkg::CNT_FLAG_END) begin
            d.cnt = trf_pkg::CNT_ZERO;
            // R4: leave only after radio flags
            // R5: a full flag always precedes
            if (q.flag_seen || hit) begin
              d.st = trf_pkg::TRF_WCNT;
            end
          end
        end
      end
      trf_pkg::TRF_WCNT: begin
        if (bit_en) begin
          // lsb first
          d.tx  = q.wcnt[q.cnt[3:0]];
          d.cnt = q.cnt + 7'h01;
          if (q.cnt == trf_pkg::CNT_WCNT_END) begin
            d.cnt = trf_pkg::CNT_ZERO;
            if (q.left != trf_pkg::LEN_ZERO) begin
              d.st = trf_pkg::TRF_DATA;
            end else begin
              d.st   = trf_pkg::TRF_IDLE;
              d.done = 1'b1;
            end
          end
        end
      end
      trf_pkg::TRF_DATA: begin
        if (bit_en) begin
          // R7: coded bits go out untouched
          d.tx   = data_bit_in;
          d.left = q.left - 16'h0001;
          if (q.left == trf_pkg::LEN_ONE) begin
            if (q.pad != trf_pkg::PAD_ZERO) begin
              d.st = trf_pkg::TRF_PAD;
            end else begin
              d.st   = trf_pkg::TRF_IDLE;
              d.done = 1'b1;
            end
          end
        end
      end
      trf_pkg::TRF_PAD: begin
        if (bit_en) begin
          // R3: raw zeros, never fed to coding
          d.tx  = trf_pkg::PAD_LEVEL;
          d.pad = q.pad - 4'h1;
          if (q.pad == trf_pkg::PAD_ONE) begin
            d.st   = trf_pkg::TRF_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default: begin
        d.st = trf_pkg::TRF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      q    <= '0;
      q.st <= trf_pkg::TRF_IDLE;
      q.tx <= trf_pkg::IDLE_LEVEL;
    end else begin
      q <= d;
    end
  end

  // ready and data request combinational, done and data from flops
  assign req_ready_out         = (q.st == trf_pkg::TRF_IDLE);
  assign data_req_out          = (q.st == trf_pkg::TRF_DATA) && bit_en;
  assign done_out              = q.done;
  assign tx_lead_out           = q.tx;
  assign phy_status_report_out = q.net;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  wcnt_value_a: assert property ( // R1
    take |=> (32'(q.wcnt) * trf_pkg::WORD_BITS >=
              32'($past(req_in.len)) + trf_pkg::WCNT_BITS) &&
             (32'(q.wcnt) * trf_pkg::WORD_BITS <
              32'($past(req_in.len)) + trf_pkg::WCNT_BITS +
              trf_pkg::WORD_BITS))
    else $error("word count wrong");
  pad_count_a: assert property ( // R2
    take |=> (5'(q.pad) + 5'($past(req_in.len[3:0]))) % 5'h10 == 5'h00)
    else $error("pad count wrong");
  pad_zero_a: assert property ( // R3
    (q.st == trf_pkg::TRF_PAD) && bit_en |=> !tx_lead_out)
    else $error("pad bit not zero");
  flag_hold_a: assert property ( // R4
    (q.st == trf_pkg::TRF_FLAG) && bit_en && !q.flag_seen && !hit
    |=> q.st == trf_pkg::TRF_FLAG)
    else $error("left flags without radio flag");
  lead_flag_a: assert property ( // R5
    $rose(q.st == trf_pkg::TRF_WCNT) && q.packet
    |-> $past(q.st) == trf_pkg::TRF_FLAG &&
        $past(q.cnt) == trf_pkg::CNT_FLAG_END)
    else $error("data without full lead flag");
  data_pass_a: assert property ( // R7
    (q.st == trf_pkg::TRF_DATA) && bit_en
    |=> tx_lead_out == $past(data_bit_in))
    else $error("data bit altered");
  bitsync_a: assert property ( // R8
    (q.st == trf_pkg::TRF_BSYNC) && bit_en
    |=> tx_lead_out == !$past(q.cnt[0]))
    else $error("bit sync pattern wrong");
  busy_set_a: assert property ( // R9
    q.sync[2:1] != 2'h0 |=> phy_status_report_out.busy)
    else $error("busy not set");
  busy_clr_a: assert property ( // R10
    $fell(phy_status_report_out.busy) |-> $past(q.sync[2:1]) == 2'h0)
    else $error("busy cleared while active");
  report_a: assert property ( // R11
    phy_status_report_out.report
    |-> phy_status_report_out.busy != $past(phy_status_report_out.busy))
    else $error("report without change");
  no_phase_a: assert property ( // R12
    take && req_in.packet |=> q.st == trf_pkg::TRF_FLAG)
    else $error("phasing before flags");
  flag_bits_a: assert property ( // R13
    (q.st == trf_pkg::TRF_FLAG) && bit_en
    |=> tx_lead_out == trf_pkg::FLAG_PATTERN[$past(q.cnt[2:0])])
    else $error("flag pattern wrong");

  wcnt_bits_a: assert property ( // R1
    (q.st == trf_pkg::TRF_WCNT) && bit_en
    |=> tx_lead_out == $past(q.wcnt[q.cnt[3:0]]))
    else $error("word count bit wrong");
  pad_last_a: assert property ( // R2
    (q.st == trf_pkg::TRF_PAD) && bit_en && (q.pad == trf_pkg::PAD_ONE)
    |=> done_out && (q.st == trf_pkg::TRF_IDLE))
    else $error("padding did not close unit");
  done_edge_a: assert property ( // R2
    done_out |-> $past(bit_en) && (q.st == trf_pkg::TRF_IDLE))
    else $error("unit closed off a bit edge");
  flag_whole_a: assert property ( // R5
    (q.st == trf_pkg::TRF_FLAG) && bit_en &&
    (q.cnt != trf_pkg::CNT_FLAG_END) |=> q.st == trf_pkg::TRF_FLAG)
    else $error("lead flag cut short");
  flag_mode_a: assert property ( // R5
    (q.st == trf_pkg::TRF_FLAG) |-> q.packet)
    else $error("flags outside packet mode");
  data_req_a: assert property ( // R7
    data_req_out |-> (q.st == trf_pkg::TRF_DATA) &&
    (q.left != trf_pkg::LEN_ZERO))
    else $error("data asked past field end");
  data_end_a: assert property ( // R7
    (q.st == trf_pkg::TRF_DATA) && bit_en && (q.left == trf_pkg::LEN_ONE)
    |=> q.st != trf_pkg::TRF_DATA)
    else $error("data field overran");
  bsync_first_a: assert property ( // R8
    $rose(q.st == trf_pkg::TRF_BSYNC) |-> q.cnt == trf_pkg::CNT_ZERO)
    else $error("bit sync not from start");
  report_off_a: assert property ( // R11
    !report_en_in |=> !phy_status_report_out.report)
    else $error("report while disabled");
  bsync_pk_a: assert property ( // R12
    (q.st == trf_pkg::TRF_BSYNC) |-> !q.packet)
    else $error("alternating bits in packet mode");
  tx_idle_a: assert property ( // R12
    (q.st == trf_pkg::TRF_IDLE) && bit_en
    |=> tx_lead_out == trf_pkg::IDLE_LEVEL)
    else $error("lead not idle between units");

  packet_send_c: cover property (
    take && req_in.packet ##[1:1000] done_out);
  bitsync_c: cover property (
    q.st == trf_pkg::TRF_BSYNC ##1 q.st == trf_pkg::TRF_WCNT);
  flag_wait_c: cover property (
    (q.st == trf_pkg::TRF_FLAG) && bit_en && !q.flag_seen);
  pad_c: cover property (q.st == trf_pkg::TRF_PAD ##1 done_out);
  busy_c: cover property ($fell(phy_status_report_out.busy));

endmodule : trf_framer

// File: logic/trf_pkg.sv
/*
  shared constants and types of the transmission unit framer.
  assumes a 200 MHz core clock; bit rate set by the divider figure.
*/
package trf_pkg;

  // clock and bit timing
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned BIT_TIME_NS     = 62500;
  localparam int unsigned BIT_CYCLES_DFLT =
    (BIT_TIME_NS * 1000) / CLK_PERIOD_PS;

  // field sizes
  localparam int unsigned WORD_BITS    = 16;
  localparam int unsigned WORD_SHIFT   = 4;
  localparam int unsigned WCNT_BITS    = 16;
  localparam int unsigned FLAG_BITS    = 8;
  localparam int unsigned BITSYNC_BITS = 64;
  localparam int unsigned NET_DET_W    = 2;

  // field positions and counter limits
  localparam logic [6:0] CNT_ZERO     = 7'h00;
  localparam logic [6:0] CNT_FLAG_END = 7'(FLAG_BITS - 1);
  localparam logic [6:0] CNT_WCNT_END = 7'(WCNT_BITS - 1);
  localparam logic [6:0] CNT_BS_END   = 7'(BITSYNC_BITS - 1);
  localparam logic [15:0] DIV_ZERO    = 16'h0000;
  localparam logic [15:0] LEN_ONE     = 16'h0001;
  localparam logic [15:0] LEN_ZERO    = 16'h0000;
  localparam logic [3:0]  PAD_ONE     = 4'h1;
  localparam logic [3:0]  PAD_ZERO    = 4'h0;

  // line patterns
  localparam logic [7:0] FLAG_PATTERN = 8'h7e;
  localparam logic       IDLE_LEVEL   = 1'b1;
  localparam logic       PAD_LEVEL    = 1'b0;

  typedef enum logic [2:0] {
    TRF_IDLE,
    TRF_BSYNC,
    TRF_FLAG,
    TRF_WCNT,
    TRF_DATA,
    TRF_PAD
  } trf_state_e;

  // request from the upper layer
  typedef struct packed {
    logic [15:0] len;
    logic        packet;
    logic        bitsync;
  } trf_req_s;

  // net sensing outputs
  typedef struct packed {
    logic busy;
    logic report;
  } trf_net_s;

  typedef struct packed {
    logic [7:0] sh;
    logic       hit;
  } trf_fdet_s;

  typedef struct packed {
    trf_state_e           st;
    logic [15:0]          div;
    logic [6:0]           cnt;
    logic [15:0]          left;
    logic [15:0]          wcnt;
    logic [3:0]           pad;
    logic                 packet;
    logic                 tx;
    logic                 flag_seen;
    logic                 done;
    trf_net_s             net;
    logic [NET_DET_W:0]   meta;
    logic [NET_DET_W:0]   sync;
  } trf_main_s;

endpackage : trf_pkg

// File: logic/trf_flag_det.sv
/*
  flag recogniser on a serial lead.
  assumes bit_en_in marks one sampled bit; bit_in already synchronised.
*/
`timescale 1ns/1ps
module trf_flag_det (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_in,
  // serial bits
  input  wire logic bit_en_in,
  input  wire logic bit_in,
  // one-cycle flag seen
  output logic      hit_out
);

  trf_pkg::trf_fdet_s q;
  trf_pkg::trf_fdet_s d;

  always_comb begin
    d     = q;
    d.hit = 1'b0;
    if (bit_en_in) begin
      // lsb first, newest bit enters at the top
      d.sh  = {bit_in, q.sh[7:1]};
      d.hit = ({bit_in, q.sh[7:1]} == trf_pkg::FLAG_PATTERN);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      q    <= '0;
      // idle lead is high; a zeroed history could fake a flag
      q.sh <= '1;
    end else begin
      q <= d;
    end
  end

  assign hit_out = q.hit;

endmodule : trf_flag_det

// File: test/trf_radio_model.sv
/* radio side of the leads: sends flags on answer_en_in, never watching the terminal lead.
   assumes the framer's bit time; answer_en_in paces the reply. */
`timescale 1ns/1ps
module trf_radio_model #(
  parameter int unsigned BIT_CYCLES = 4
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_in,
  // reply control and lead
  input  wire logic answer_en_in,
  output logic      rx_lead_out
);
  logic [15:0] div_q;
  logic [2:0]  pos_q;
  // change mid-bit so the framer never samples on an edge
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      div_q       <= 16'h0000;
      pos_q       <= 3'h0;
      rx_lead_out <= 1'b1;
    end else begin
      div_q <= (div_q == 16'(BIT_CYCLES - 1)) ? 16'h0000 : div_q + 16'h0001;
      if (div_q == 16'h0001) begin
        if (answer_en_in || pos_q != 3'h0) begin
          rx_lead_out <= trf_pkg::FLAG_PATTERN[pos_q];
          pos_q       <= pos_q + 3'h1;
        end else begin
          rx_lead_out <= 1'b1;
        end
      end
    end
  end
endmodule : trf_radio_model

// File: test/tb_tactical_radio_tx_unit_framer.sv
/* bench for the unit framer with a radio model on the receive lead.
   assumes a 4-cycle bit time so units stay short. */
`timescale 1ns/1ps
module tb_tactical_radio_tx_unit_framer;
  localparam int unsigned BC  = 4;
  localparam logic [63:0] PAT = 64'h3c5a_96e1_0ff0_a5c3;
  logic              mclk_in = 1'b0;
  logic              reset_in = 1'b1;
  logic              send = 1'b0;
  trf_pkg::trf_req_s req = '0;
  logic              ready, done, dreq, tx, rx;
  logic              dbit = PAT[0];
  logic              dd = 1'b0, vd = 1'b0, ren = 1'b0, ans = 1'b0;
  logic              coll = 1'b0;
  trf_pkg::trf_net_s net;
  int                failures = 0, tests_run = 0, cyc = 0, ph = 0, idx = 0;
  logic              smp[$];
  int                scyc[$];

  initial forever #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (dreq) begin
      idx  <= idx + 1;
      dbit <= PAT[6'(idx + 1)];
    end
  end
  // bit phase learnt from data requests, lead sampled mid-cycle
  always @(negedge mclk_in) begin
    if (dreq) ph = cyc % 4;
    if (coll) begin
      smp.push_back(tx);
      scyc.push_back(cyc);
    end
  end

  trf_framer #(.BIT_CYCLES(BC)) dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .phy_send_request_in(send), .req_in(req), .req_ready_out(ready),
    .done_out(done), .data_req_out(dreq), .data_bit_in(dbit),
    .tx_lead_out(tx), .rx_lead_in(rx), .data_detect_in(dd),
    .voice_detect_in(vd), .report_en_in(ren), .phy_status_report_out(net));
  trf_radio_model #(.BIT_CYCLES(BC)) radio (.mclk_in(mclk_in),
    .reset_in(reset_in), .answer_en_in(ans), .rx_lead_out(rx));

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", w, e, g);
    end
  endtask : chk

  task automatic run_unit(input logic [15:0] len, input logic pk,
                          input logic bs, input int hold);
    int t0, n, nf, i, pad, i0;
    logic [15:0] tw;
    logic exp[$];
    logic got[$];
    @(posedge mclk_in);
    req <= '{len: len, packet: pk, bitsync: bs};
    send <= 1'b1;
    ans <= (hold == 0);
    smp.delete();
    scyc.delete();
    coll = 1'b1;
    t0 = cyc + 1;
    i0 = idx;
    @(posedge mclk_in);
    send <= 1'b0;
    for (n = 0; n < 6000 && done !== 1'b1; n++) begin
      @(posedge mclk_in);
      if (n == hold) ans <= 1'b1;
      if (n == 2) chk("ready while sending", 0, ready);
    end
    if (n == 6000) begin
      chk("done", 1, 0);
      report_and_stop();
    end
    @(posedge mclk_in);
    coll = 1'b0;
    foreach (smp[k])
      if (scyc[k] >= t0 + 3 && (scyc[k] - ph) % 4 == 2) got.push_back(smp[k]);
    pad = (16 - int'(len % 16)) % 16;
    for (i = 0; i < 64 && bs; i++) exp.push_back(i % 2 == 0);
    nf = (got.size() - 16 - int'(len) - pad - (bs ? 64 : 0)) / 8;
    if (pk) chk("lead flags", 1, nf >= 1 && nf * 32 >= hold);
    for (i = 0; i < nf * 8 && pk; i++)
      exp.push_back(trf_pkg::FLAG_PATTERN[i % 8]);
    tw = 16'((32'(len) + 31) / 16);
    for (i = 0; i < 16; i++) exp.push_back(tw[i]);
    for (i = 0; i < len; i++) exp.push_back(PAT[6'(i0 + i)]);
    for (i = 0; i < pad; i++) exp.push_back(1'b0);
    chk("unit length", exp.size(), got.size());
    for (i = 0; i < exp.size() && i < got.size(); i++)
      chk("unit bit", exp[i], got[i]);
  endtask : run_unit

  task automatic net_check(input logic en);
    int n;
    logic rep, drop;
    ren <= en;
    dd <= 1'b1;
    rep = 1'b0;
    drop = 1'b0;
    for (n = 0; n < 8 && net.busy !== 1'b1; n++) begin
      @(posedge mclk_in);
      rep |= net.report;
    end
    chk("busy set", 1, net.busy);
    chk("report on set", en, rep);
    vd <= 1'b1;
    dd <= 1'b0;
    repeat (10) begin
      @(posedge mclk_in);
      drop |= (net.busy !== 1'b1) | net.report;
    end
    chk("busy on voice", 0, drop);
    vd <= 1'b0;
    rep = 1'b0;
    for (n = 0; n < 8 && net.busy !== 1'b0; n++) begin
      @(posedge mclk_in);
      rep |= net.report;
    end
    chk("busy clear", 0, net.busy);
    chk("report on clear", en, rep);
  endtask : net_check

  initial begin
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    chk("idle lead", 1, tx);
    run_unit(16'd20, 1'b0, 1'b0, 0);
    run_unit(16'd32, 1'b0, 1'b1, 0);
    run_unit(16'd0, 1'b0, 1'b0, 0);
    run_unit(16'd17, 1'b1, 1'b0, 0);
    ans <= 1'b0;
    repeat (80) @(posedge mclk_in);
    run_unit(16'd5, 1'b1, 1'b0, 200);
    net_check(1'b1);
    @(posedge mclk_in);
    net_check(1'b0);
    report_and_stop();
  end
endmodule : tb_tactical_radio_tx_unit_framer
